// ---- common/tcc_pkg.sv ----
/*
  Package for the timer counter control block: register offsets, field positions,
  reset values, count-source codes and the bus/data carrier structs.
  Assumes a 32-bit Avalon-MM word bus with byte addresses.
*/
package tcc_pkg;

  // register byte offsets
  localparam logic [3:0] ADDR_COUNTER_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_COUNTER_START   = 4'h4;
  localparam logic [3:0] ADDR_TIMER_COUNT     = 4'h8;
  localparam logic [3:0] ADDR_COMPARE_A       = 4'hc;

  // counter_control field positions
  localparam int BIT_CLEAR_ON_MATCH_A = 7;
  localparam int BIT_SOURCE_HI        = 6;
  localparam int BIT_SOURCE_LO        = 4;
  localparam int BIT_INITIAL_LEVEL_D  = 3;
  localparam int BIT_INITIAL_LEVEL_C  = 2;
  localparam int BIT_INITIAL_LEVEL_B  = 1;

  // reset values
  localparam logic [7:0]  RESET_COUNTER_CONTROL = 8'h00;
  localparam logic [15:0] RESET_TIMER_COUNT     = 16'h0000;
  localparam logic [15:0] RESET_COMPARE_A       = 16'hffff;
  localparam logic [2:0]  RESET_PRESCALE        = 3'h0;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  // count source codes
  typedef enum logic [2:0] {
    TCC_SRC_DIV1 = 3'b000,
    TCC_SRC_DIV2 = 3'b001,
    TCC_SRC_DIV4 = 3'b010,
    TCC_SRC_DIV8 = 3'b011
  } tcc_source_type;

  // decoded control register
  typedef struct packed {
    logic       clear_on_match_a;
    logic [2:0] count_source_sel;
    logic       initial_level_d;
    logic       initial_level_c;
    logic       initial_level_b;
    logic       unused_bit0;
  } tcc_control_type;

  // compare-match event group from the rest of the timer
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic match_c;
    logic match_d;
  } tcc_match_type;

  // output-compare pin group
  typedef struct packed {
    logic pin_b;
    logic pin_c;
    logic pin_d;
  } tcc_pins_type;

endpackage : tcc_pkg

// ---- design/tcc_timer_control.sv ----
/*
  Timer counter control: count-source selection (prescaler or external event edge),
  clear on compare match A, counter start, and initial levels of compare pins B/C/D,
  with the 16-bit counter itself and an Avalon-MM register slave.
  Assumes a single 25 MHz clock, match events from the compare logic on the same clock,
  and the external event and subclock inputs arriving asynchronously.
*/
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module tcc_timer_control (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // timer side
  input  wire logic                   external_event_in,
  input  wire logic                   subclock_in,
  input  wire logic                   low_speed_mode,
  input  wire tcc_pkg::tcc_match_type match_in,
  output tcc_pkg::tcc_pins_type       pins_out,
  output logic [15:0]                 timer_count,
  output logic                        match_a_out
);

  // state kept by this block
  // control and start are software owned, the counter is shared
  // between software writes, clear on match a and the count enable;
  // everything below sits in the clk_sys domain after the synchronisers
  // register state
  tcc_pkg::tcc_control_type counter_control;
  logic                     counter_start;
  logic [15:0]              compare_a;
  logic                     answered;
  logic [2:0]               prescale;
  logic [tcc_pkg::SYNC_STAGES-1:0] event_sync;
  logic                     event_last;
  logic [tcc_pkg::SYNC_STAGES-1:0] sub_sync;
  logic                     sub_last;
  logic                     mode_sync_0;
  logic                     mode_sync_1;
  logic                     seen_b;
  logic                     seen_c;
  logic                     seen_d;
  logic                     next_count_en;
  logic                     match_a_int;
  logic                     wr_ctl;
  logic                     wr_start;
  logic                     wr_count;
  logic                     wr_cmp;
  logic [31:0]              next_readdata;

  // one compare per register, shared by read mux and write strobes
  // so that a read and a write of one offset can never disagree
  // address decode helper, used for both reads and writes
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] target);
    hit = (addr == target);
  endfunction : hit

  // every request costs exactly two cycles:
  // first cycle waitrequest high, read data captured,
  // second cycle waitrequest low, write takes effect;
  // answered drops again so back to back requests see a fresh wait
  // bus handshake: one wait cycle, then answer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      answered <= 1'b0;
    end else begin
      answered <= (avs_read || avs_write) && !answered;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !answered;

  // write strobes only in the answered cycle
  // control and start live in byte lane 0 and need it enabled;
  // the counter is written whole, lanes ignored, so a partial
  // write can never leave a torn count behind

  assign wr_ctl   = avs_write && answered && hit(avs_address, tcc_pkg::ADDR_COUNTER_CONTROL) && avs_byteenable[0];
  assign wr_start = avs_write && answered && hit(avs_address, tcc_pkg::ADDR_COUNTER_START) && avs_byteenable[0];
  assign wr_count = avs_write && answered && hit(avs_address, tcc_pkg::ADDR_TIMER_COUNT);
  assign wr_cmp   = avs_write && answered && hit(avs_address, tcc_pkg::ADDR_COMPARE_A);

  // a control write takes effect on the next count decision:
  // a new source code is used from the following cycle on,
  // so one count may be lost or gained at the switch
  // control register, bit 0 kept as stored but has no effect
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_control <= tcc_pkg::RESET_COUNTER_CONTROL;
    end else if (wr_ctl) begin
      counter_control <= avs_writedata[7:0];
    end
  end

  // counting gate for the whole timer
  // clearing it freezes the counter but not the prescaler,
  // so the first divided count after a restart may come early
  // counter start bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      counter_start <= 1'b0;
    end else if (wr_start) begin
      counter_start <= avs_writedata[0];
    end
  end

  // resets to all ones so that a counter started before software
  // sets a compare value runs a full turn before its first match
  // compare value for match a, byte lanes honoured
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      compare_a <= tcc_pkg::RESET_COMPARE_A;
    end else if (wr_cmp) begin
      if (avs_byteenable[0]) begin
        compare_a[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        compare_a[15:8] <= avs_writedata[15:8];
      end
    end
  end

  // unused upper bits of every register read as zero
  // the counter value is the one before the answering edge,
  // a count landing in the wait cycle is not seen by this read
  // read mux, unmapped reads give zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit(avs_address, tcc_pkg::ADDR_COUNTER_CONTROL)) begin
      next_readdata[7:0] = counter_control;
    end else if (hit(avs_address, tcc_pkg::ADDR_COUNTER_START)) begin
      next_readdata[0] = counter_start;
    end else if (hit(avs_address, tcc_pkg::ADDR_TIMER_COUNT)) begin
      next_readdata[15:0] = timer_count;
    end else if (hit(avs_address, tcc_pkg::ADDR_COMPARE_A)) begin
      next_readdata[15:0] = compare_a;
    end
  end

  // registered so the data output never glitches with the address;
  // the value then stands until the next read request
  // read data registered during the wait cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !answered) begin
      avs_readdata <= next_readdata;
    end
  end

  // one shared divider for the /2, /4 and /8 sources
  // it never stops or clears, so divided counts keep a fixed phase
  // against reset and are exact over any run of 8 cycles
  // free-running prescaler
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= tcc_pkg::RESET_PRESCALE;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end

  // the event pin is asynchronous: two flops before any logic,
  // then one more flop for the edge compare;
  // a rising edge becomes a count three cycles after the pin
  // and pulses shorter than one clock period may be lost
  // external event synchroniser and edge memory
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      event_sync <= '0;
      event_last <= 1'b0;
    end else begin
      event_sync <= {event_sync[0], external_event_in};
      event_last <= event_sync[1];
    end
  end

  // subclock is sampled like the event pin; it must run well
  // below half the system clock for every edge to be counted
  // subclock synchroniser and edge memory
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sub_sync <= '0;
      sub_last <= 1'b0;
    end else begin
      sub_sync <= {sub_sync[0], subclock_in};
      sub_last <= sub_sync[1];
    end
  end

  // low-speed state is a level; only the second flop is read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_sync_0 <= 1'b0;
      mode_sync_1 <= 1'b0;
    end else begin
      mode_sync_0 <= low_speed_mode;
      mode_sync_1 <= mode_sync_0;
    end
  end

  // one enable pulse per count, whatever the source:
  // top bit set picks the event edge and ignores the low bits,
  // otherwise the divider taps, or the subclock edge when the
  // undivided clock is chosen while in the low-speed state
  // count enable selection
  always_comb begin
    next_count_en = 1'b0;
    if (counter_control.count_source_sel[2]) begin
      next_count_en = event_sync[1] && !event_last;
    end else begin
      case (tcc_pkg::tcc_source_type'(counter_control.count_source_sel))
        tcc_pkg::TCC_SRC_DIV1: next_count_en = mode_sync_1 ? (sub_sync[1] && !sub_last) : 1'b1;
        tcc_pkg::TCC_SRC_DIV2: next_count_en = (prescale[0] == 1'b1);
        tcc_pkg::TCC_SRC_DIV4: next_count_en = (prescale[1:0] == 2'h3);
        tcc_pkg::TCC_SRC_DIV8: next_count_en = (prescale == 3'h7);
        default:               next_count_en = 1'b0;
      endcase
    end
  end

  // the local compare only matters while the counter runs,
  // so a stopped counter resting on the compare value is quiet
  // compare match a from the local compare or the outside compare logic
  assign match_a_int = match_in.match_a || (counter_start && timer_count == compare_a);
  assign match_a_out = match_a_int;

  // priority: software write, then clear on match a, then count;
  // clearing on match gives a period of compare value plus one only on the undivided system clock; the clear does not wait for a count enable
  // timer counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= tcc_pkg::RESET_TIMER_COUNT;
    end else if (wr_count) begin
      timer_count <= avs_writedata[15:0];
    end else if (counter_control.clear_on_match_a && match_a_int) begin
      timer_count <= 16'h0000;
    end else if (counter_start && next_count_en) begin
      timer_count <= timer_count + 16'h0001;
    end
  end

  // first-match memory per pin; a control write restarts the initial level
  // a match in the same cycle as the control write wins, so the pin
  // is not sent back to its initial level by that write after it has toggled
  // first-match memory, pin b
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_b <= 1'b0;
    end else begin
      seen_b <= match_in.match_b || (seen_b && !wr_ctl);
    end
  end

  // first-match memory, pin c
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_c <= 1'b0;
    end else begin
      seen_c <= match_in.match_c || (seen_c && !wr_ctl);
    end
  end

  // first-match memory, pin d
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_d <= 1'b0;
    end else begin
      seen_d <= match_in.match_d || (seen_d && !wr_ctl);
    end
  end

  // pins follow the control bits one cycle after a control write;
  // after the first match the level belongs to the compare logic
  // and only toggles, a later control write re-arms the level
  // output pins: initial level until first match, then toggle per match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins_out <= '0;
    end else begin
      if (!seen_b && !match_in.match_b) begin
        pins_out.pin_b <= counter_control.initial_level_b;
      end else if (match_in.match_b) begin
        pins_out.pin_b <= ~pins_out.pin_b;
      end
      if (!seen_c && !match_in.match_c) begin
        pins_out.pin_c <= counter_control.initial_level_c;
      end else if (match_in.match_c) begin
        pins_out.pin_c <= ~pins_out.pin_c;
      end
      if (!seen_d && !match_in.match_d) begin
        pins_out.pin_d <= counter_control.initial_level_d;
      end else if (match_in.match_d) begin
        pins_out.pin_d <= ~pins_out.pin_d;
      end
    end
  end

endmodule : tcc_timer_control

// ---- test/tcc_chk.sv ----
/*
  checker for tcc_timer_control: shadows control and start from bus writes.
  assumes binding to the design top, one clock domain.
*/
`timescale 1ns/1ps
module tcc_chk (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic [3:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic                   external_event_in,
  input wire logic                   subclock_in,
  input wire logic                   low_speed_mode,
  input wire tcc_pkg::tcc_match_type match_in,
  input wire tcc_pkg::tcc_pins_type  pins_out,
  input wire logic [15:0]            timer_count,
  input wire logic                   match_a_out
);
  logic [7:0] ctl;
  logic       run_en;
  logic [2:0] armed;
  wire acc    = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire wr_ctl = acc && avs_address == 4'h0;
  wire wr_cnt = acc && avs_address == 4'h8;
  wire run    = run_en && !wr_cnt && !(ctl[7] && match_a_out);
  // shadow of control and start
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl <= 8'h00;
      run_en <= 1'b0;
    end else begin
      if (wr_ctl) ctl <= avs_writedata[7:0];
      if (acc && avs_address == 4'h4) run_en <= avs_writedata[0];
    end
  end
  // pins still at their initial level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) armed <= 3'h7;
    else if (wr_ctl) armed <= 3'h7;
    else armed <= armed & ~{match_in.match_b, match_in.match_c, match_in.match_d};
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_clear_on_a: assert property (ctl[7] && match_a_out && run_en && !wr_cnt |=> timer_count == 16'h0)
    else $error("counter not cleared on match a");
  a_free_step: assert property (run && ctl[7:4] == 4'h0 && !low_speed_mode
    |=> timer_count == $past(timer_count) + 16'h1)
    else $error("counter did not step by one");
  a_hold_stop: assert property (!run_en && !wr_cnt && !match_a_out |=> $stable(timer_count))
    else $error("counter moved while stopped");
  a_div_two: assert property (run && $past(run) && ctl[6:4] == 3'h1 && $changed(timer_count)
    |=> !$changed(timer_count) ##1 ($changed(timer_count) || !$past(run)))
    else $error("divide by two period wrong");
  a_ext_edge: assert property ($rose(external_event_in) && ctl[6] && run_en |-> ##[2:4] $changed(timer_count))
    else $error("event edge not counted");
  a_sub_edge: assert property ($rose(subclock_in) && low_speed_mode && ctl[6:4] == 3'h0 && run_en
    |-> ##[2:4] $changed(timer_count))
    else $error("subclock edge not counted");
  a_pin_level: assert property (!$past(wr_ctl)
    |-> ((pins_out ^ {ctl[1], ctl[2], ctl[3]}) & armed) == 3'h0)
    else $error("pin not at initial level");
  a_ctl_read: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0
    |-> avs_readdata[7:0] == ctl)
    else $error("control readback wrong");
endmodule : tcc_chk

bind tcc_timer_control tcc_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_event_in(external_event_in),
  .subclock_in(subclock_in), .low_speed_mode(low_speed_mode), .match_in(match_in), .pins_out(pins_out),
  .timer_count(timer_count), .match_a_out(match_a_out));

// ---- test/tcc_timer_control_bench.sv ----
/*
  testbench for tcc_timer_control: count windows per source, clear, pins, readback.
  assumes the checker is bound; 25 MHz clock.
*/
`timescale 1ns/1ps
module tcc_timer_control_bench;
  typedef struct packed { logic [7:0] ctl; logic lsm; logic [15:0] exp; } tcc_row_type;
  logic                   clk_sys = 1'b0;
  logic                   rst_n = 1'b0;
  logic [3:0]             avs_address = 4'h0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [3:0]             avs_byteenable = 4'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   ext_in = 1'b0;
  logic                   sub_in = 1'b0;
  logic                   lsm = 1'b0;
  tcc_pkg::tcc_match_type match_in = 4'h0;
  tcc_pkg::tcc_pins_type  pins_out;
  logic [15:0]            timer_count;
  logic                   match_a_seen;
  logic [31:0]            rd;
  logic [15:0]            cnt;
  int                     mismatches = 0;
  int                     cmp_count = 0;
  tcc_row_type            rows [8] = '{{8'h00, 1'h0, 16'h20}, {8'h12, 1'h0, 16'h10}, {8'h24, 1'h0, 16'h08},
    {8'h38, 1'h0, 16'h04}, {8'h4e, 1'h0, 16'h03}, {8'h70, 1'h0, 16'h03}, {8'h0a, 1'h1, 16'h03},
    {8'h16, 1'h1, 16'h10}};

  tcc_timer_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_event_in(ext_in),
    .subclock_in(sub_in), .low_speed_mode(lsm), .match_in(match_in), .pins_out(pins_out),
    .timer_count(timer_count), .match_a_out(match_a_seen));

  // free-running system clock
  always #20 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
    int n = 0;
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      test_done();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_byteenable <= 4'h0;
    @(posedge clk_sys);
  endtask : bus

  // 32 counting edges with three event and subclock pulses inside
  task automatic run_window(input logic [7:0] ctl, input logic mode, output logic [15:0] val);
    lsm <= mode;
    bus(1'b1, 4'h0, {24'h0, ctl});
    bus(1'b1, 4'h8, 32'h0);
    bus(1'b1, 4'h4, 32'h1);
    repeat (3) begin
      ext_in <= 1'b1;
      sub_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      ext_in <= 1'b0;
      sub_in <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
    repeat (2) @(posedge clk_sys);
    bus(1'b1, 4'h4, 32'h0);
    lsm <= 1'b0;
    bus(1'b0, 4'h8, 32'h0);
    val = rd[15:0];
  endtask : run_window

  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0);
    check("reset control", rd, 32'h0);
    check("reset count", {16'h0, timer_count}, 32'h0);
    // table of source codes
    foreach (rows[i]) begin
      run_window(rows[i].ctl, rows[i].lsm, cnt);
      check("count", {16'h0, cnt}, {16'h0, rows[i].exp});
      bus(1'b0, 4'h0, 32'h0);
      check("control", rd, {24'h0, rows[i].ctl});
      check("pins", {29'h0, pins_out}, {29'h0, rows[i].ctl[1], rows[i].ctl[2], rows[i].ctl[3]});
    end
    // clear on match a against free running
    bus(1'b1, 4'hc, 32'h9);
    run_window(8'h80, 1'b0, cnt);
    check("clear count", {16'h0, cnt}, 32'h2);
    run_window(8'h00, 1'b0, cnt);
    check("free count", {16'h0, cnt}, 32'h20);
    // first match ends the initial level, a control write re-arms it
    bus(1'b1, 4'h0, 32'h0e);
    match_in <= 4'h7;
    @(posedge clk_sys);
    match_in <= 4'h0;
    repeat (2) @(posedge clk_sys);
    check("pins matched", {29'h0, pins_out}, 32'h0);
    bus(1'b1, 4'h0, 32'h04);
    @(posedge clk_sys);
    check("pins rearmed", {29'h0, pins_out}, 32'h2);
    bus(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    // outside match a passes to the match output
    match_in <= 4'h8;
    @(posedge clk_sys);
    check("match a out", {31'h0, match_a_seen}, 32'h1);
    match_in <= 4'h0;
    @(posedge clk_sys);
    check("match a idle", {31'h0, match_a_seen}, 32'h0);
    // reset with the counter stopped at a nonzero count returns counter, pins and control to zero
    rst_n <= 1'b0;
    @(posedge clk_sys);
    check("reset mid count", {16'h0, timer_count}, 32'h0);
    check("reset mid pins", {29'h0, pins_out}, 32'h0);
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0);
    check("reset mid control", rd, 32'h0);
    test_done();
  end
endmodule : tcc_timer_control_bench
